// *** pkg/twu_pkg.sv ***
// two-wire unit package: register map, field positions, status codes, carriers
// assumes 8-bit registers, each in the low byte of one 32-bit bus word
package twu_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h93;
    localparam logic [7:0] IDX_CODE = 8'h94;
    localparam logic [7:0] IDX_DATA = 8'h95;
    localparam logic [7:0] IDX_OADR = 8'h96;
    localparam logic [9:0] ADR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADR_CODE = {IDX_CODE, 2'b00};
    localparam logic [9:0] ADR_DATA = {IDX_DATA, 2'b00};
    localparam logic [9:0] ADR_OADR = {IDX_OADR, 2'b00};
    // bus_control fields
    localparam int B_RATE2 = 7;
    localparam int B_ENA   = 6;
    localparam int B_STA   = 5;
    localparam int B_STO   = 4;
    localparam int B_SI    = 3;
    localparam int B_AA    = 2;
    localparam int B_RATE1 = 1;
    localparam int B_RATE0 = 0;
    // own_address field
    localparam int B_GC    = 0;
    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] OADR_RST = 8'h00;
    // link clock cycles in one half period at the fastest rate
    localparam logic [15:0] HALF_DEF = 16'h0008;
    // bus state codes
    localparam logic [7:0] SC_BUS_ERR = 8'h00, SC_START = 8'h08, SC_RSTART = 8'h10;
    localparam logic [7:0] SC_MT_AACK = 8'h18, SC_MT_ANAK = 8'h20, SC_MT_DACK = 8'h28;
    localparam logic [7:0] SC_MT_DNAK = 8'h30, SC_MR_AACK = 8'h40, SC_MR_ANAK = 8'h48;
    localparam logic [7:0] SC_MR_DACK = 8'h50, SC_MR_DNAK = 8'h58, SC_SR_OWN = 8'h60;
    localparam logic [7:0] SC_SR_GEN = 8'h70, SC_SR_DACK = 8'h80, SC_SR_DNAK = 8'h88;
    localparam logic [7:0] SC_SR_GDACK = 8'h90, SC_SR_GDNAK = 8'h98, SC_SR_STOP = 8'hA0;
    localparam logic [7:0] SC_ST_OWN = 8'hA8, SC_ST_DACK = 8'hB8, SC_ST_DNAK = 8'hC0;
    localparam logic [7:0] SC_ST_LAST = 8'hC8, SC_IDLE = 8'hF8;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_START = 5'b00010,
        ST_BIT   = 5'b00100,
        ST_WAIT  = 5'b01000,
        ST_STOP  = 5'b10000
    } twu_st_t;

    // command snapshot handed to the link side with each go toggle
    typedef struct packed {
        logic       begin_condition_request;
        logic       end_condition_request;
        logic       aa;
        logic [2:0] rate;
        logic [7:0] data;
        logic [7:0] own;
    } twu_cmd_t;

    // event payload handed back with each event toggle
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        logic       si;
        logic       clr;
    } twu_evt_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [4:0] code;
        logic [7:0] data;
        logic [7:0] oadr;
        twu_cmd_t   cmd;
        logic       go, ak_m, ak_s, ev_m, ev_s, ev_d, wt;
        logic [7:0] rd;
    } twu_core_t;

    typedef struct packed {
        logic        en_m, en_s, go_m, go_s, go_d;
        logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
        twu_st_t     st;
        logic [15:0] div;
        logic [1:0]  ph;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        master, addr, tx, rw, gc, ackr, ev_tog, sda_oe, scl_oe;
        twu_evt_t    evt;
        twu_cmd_t    cmd;
    } twu_link_t;

    localparam twu_core_t CORE_RST = '{ctrl: CTRL_RST, code: SC_IDLE[7:3], data: DATA_RST,
                                       oadr: OADR_RST, wt: 1'b1, default: '0};
    localparam twu_link_t LINK_RST = '{st: ST_IDLE, default: '0};
endpackage : twu_pkg

// *** hw/twu_top.sv ***
// two-wire unit: register file on the core clock, bus engine on the link clock
// assumes open-drain pads resolved outside and an Avalon-MM master on core_clk_in
// Functional notes
// - the engine is held idle with both lines released while interface_enable is 0.
// - setting begin_condition_request makes the engine put a START on the bus when idle or as master; an addressed slave ignores it.
// - setting end_condition_request makes the master put a STOP on the bus.
// - the interrupt flag is set by hardware and stays set until software writes it to 0.
// - as a receiver the acknowledge slot carries ack_enable: 1 pulls data low, 0 leaves it high.
// - own and broadcast addresses are recognised only while ack_enable is 1.
// - in master transmitter mode ack_enable has no effect.
// - bus_control holds a three-bit rate select at bits 7, 1 and 0.
// - bus_state_code shows the five-bit state code in bits 7 to 3.
// - bus_state_code is read-only and its bits 2 to 0 read 0.
// - own_address holds the seven-bit own node address in bits 7 to 1.
// - bit 0 of own_address enables the broadcast address.
// - shift_data holds the byte shifted out or in, with the direction in bit 0 of an address.
// - an illegal START or STOP gives code 00h, releases the bus and clears the stop request.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module twu_top
    import twu_pkg::*;
#(
    parameter logic [15:0] HALF_BASE = HALF_DEF
) (
    // clocks and reset
    input  wire logic        core_clk_in,
    input  wire logic        bus_clk_in,
    input  wire logic        arst_n_in,
    // register bus
    input  wire logic [9:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // two-wire pins
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_out,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out
);
    twu_core_t  c_r, c_n;
    twu_link_t  l_r, l_n;
    twu_cmd_t   cm;
    logic       acc, wctl, c_ev, busy;
    logic [7:0] wd, rd, ec;
    logic       ev, esi, eclr, go, rise, fall, cond, half, mo, mg;
    logic [15:0] rld;

    function automatic logic [7:0] f_code(input logic m, a, t, r, k, g, aa);
        if (a && m) f_code = r ? (k ? SC_MR_AACK : SC_MR_ANAK) : (k ? SC_MT_AACK : SC_MT_ANAK);
        else if (a) f_code = r ? SC_ST_OWN : (g ? SC_SR_GEN : SC_SR_OWN);
        else if (m && t) f_code = k ? SC_MT_DACK : SC_MT_DNAK;
        else if (m) f_code = aa ? SC_MR_DACK : SC_MR_DNAK;
        else if (t) f_code = !k ? SC_ST_DNAK : (aa ? SC_ST_DACK : SC_ST_LAST);
        else if (g) f_code = aa ? SC_SR_GDACK : SC_SR_GDNAK;
        else f_code = aa ? SC_SR_DACK : SC_SR_DNAK;
    endfunction : f_code

    // core side: bus slave and registers
    always_comb begin
        c_n      = c_r;
        wd       = avs_writedata_in[7:0];
        c_n.ev_m = l_r.ev_tog;
        c_n.ev_s = c_r.ev_m;
        c_n.ev_d = c_r.ev_s;
        c_n.ak_m = l_r.go_d;
        c_n.ak_s = c_r.ak_m;
        c_ev     = c_r.ev_s != c_r.ev_d;
        // a new command waits until the link side has taken the previous one
        busy     = c_r.go != c_r.ak_s;
        acc      = avs_write_in && !c_r.wt && avs_byteenable_in[0];
        wctl     = acc && avs_address_in == ADR_CTRL;
        case (avs_address_in)
            ADR_CTRL: rd = c_r.ctrl;
            ADR_CODE: rd = {c_r.code, 3'b000};
            ADR_DATA: rd = c_r.data;
            ADR_OADR: rd = c_r.oadr;
            default:  rd = 8'h00;
        endcase
        if ((avs_read_in || avs_write_in) && c_r.wt && !(avs_write_in && avs_address_in == ADR_CTRL && busy)) begin
            c_n.wt = 1'b0;
            c_n.rd = rd;
        end else begin
            c_n.wt = 1'b1;
        end
        if (wctl) begin
            c_n.ctrl = {wd[7:4], wd[B_SI] & c_r.ctrl[B_SI], wd[2:0]};
            c_n.cmd  = '{begin_condition_request: wd[B_STA], end_condition_request: wd[B_STO], aa: wd[B_AA],
                         rate: {wd[B_RATE2], wd[B_RATE1], wd[B_RATE0]},
                         data: c_r.data, own: c_r.oadr};
            if (!c_n.ctrl[B_SI] && wd[B_ENA]) begin
                c_n.go = !c_r.go;
            end
        end
        if (acc && avs_address_in == ADR_DATA) begin
            c_n.data = wd;
        end
        if (acc && avs_address_in == ADR_OADR) begin
            c_n.oadr = wd;
        end
        // hardware set wins over a software clear in the same cycle
        if (c_ev) begin
            c_n.code = l_r.evt.code[7:3];
            if (l_r.evt.si) begin
                c_n.ctrl[B_SI] = 1'b1;
                c_n.data       = l_r.evt.data;
            end
            if (l_r.evt.clr) begin
                c_n.ctrl[B_STO] = 1'b0;
            end
        end
    end

    // link side: bus engine
    always_comb begin
        l_n       = l_r;
        ev        = 1'b0;
        ec        = SC_IDLE;
        esi       = 1'b1;
        eclr      = 1'b0;
        l_n.en_m  = c_r.ctrl[B_ENA];
        l_n.en_s  = l_r.en_m;
        l_n.go_m  = c_r.go;
        l_n.go_s  = l_r.go_m;
        l_n.go_d  = l_r.go_s;
        l_n.scl_m = scl_in;
        l_n.scl_s = l_r.scl_m;
        l_n.scl_d = l_r.scl_s;
        l_n.sda_m = sda_in;
        l_n.sda_s = l_r.sda_m;
        l_n.sda_d = l_r.sda_s;
        go        = l_r.go_s != l_r.go_d;
        rise      = l_r.scl_s && !l_r.scl_d;
        fall      = !l_r.scl_s && l_r.scl_d;
        cond      = l_r.scl_s && l_r.scl_d && (l_r.sda_s != l_r.sda_d);
        half      = l_r.div == 16'h0000;
        rld       = (HALF_BASE << l_r.cmd.rate) - 16'h0001;
        cm        = c_r.cmd;
        mo        = l_r.sh[7:1] == l_r.cmd.own[7:1];
        mg        = l_r.sh[7:1] == 7'h00 && l_r.cmd.own[B_GC] && !l_r.sh[0];
        if (!half) begin
            l_n.div = l_r.div - 16'h0001;
        end
        unique case (l_r.st)
            ST_IDLE: begin
                l_n.sda_oe = 1'b0;
                l_n.scl_oe = 1'b0;
                l_n.master = 1'b0;
                if (go) begin
                    l_n.cmd = cm;
                end
                if (go && cm.begin_condition_request) begin
                    l_n.st  = ST_START;
                    l_n.ph  = 2'd0;
                    l_n.div = rld;
                end else if (cond && !l_r.sda_s && l_r.cmd.aa) begin
                    l_n.st   = ST_BIT;
                    l_n.addr = 1'b1;
                    l_n.tx   = 1'b0;
                    l_n.cnt  = 4'd0;
                end
            end
            ST_START: begin
                if (half) begin
                    l_n.div = rld;
                    l_n.ph  = l_r.ph + 2'd1;
                    if (l_r.ph == 2'd0) begin
                        l_n.scl_oe = 1'b0;
                    end else if (l_r.ph == 2'd1) begin
                        l_n.sda_oe = 1'b1;
                    end else begin
                        l_n.scl_oe = 1'b1;
                        ev         = 1'b1;
                        ec         = l_r.master ? SC_RSTART : SC_START;
                        l_n.master = 1'b1;
                        l_n.addr   = 1'b1;
                        l_n.tx     = 1'b1;
                        l_n.st     = ST_WAIT;
                    end
                end
            end
            ST_STOP: begin
                if (half) begin
                    l_n.div = rld;
                    l_n.ph  = l_r.ph + 2'd1;
                    if (l_r.ph == 2'd0) begin
                        l_n.scl_oe = 1'b0;
                    end else if (l_r.ph == 2'd1) begin
                        l_n.sda_oe = 1'b0;
                    end else begin
                        l_n.st     = ST_IDLE;
                        l_n.master = 1'b0;
                        ev         = 1'b1;
                        esi        = 1'b0;
                        eclr       = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                // clock is held low here until software answers
                if (go) begin
                    l_n.cmd = cm;
                    l_n.div = rld;
                    l_n.ph  = 2'd0;
                    if (l_r.master && cm.end_condition_request) begin
                        l_n.st     = ST_STOP;
                        l_n.sda_oe = 1'b1;
                    end else if (l_r.master && cm.begin_condition_request) begin
                        l_n.st = ST_START;
                    end else begin
                        l_n.st     = ST_BIT;
                        l_n.cnt    = 4'd0;
                        l_n.sh     = l_r.tx ? cm.data : l_r.sh;
                        l_n.sda_oe = l_r.tx && !cm.data[7];
                        l_n.scl_oe = l_r.master;
                    end
                end
            end
            ST_BIT: begin
                if (l_r.master && half) begin
                    l_n.div    = rld;
                    l_n.scl_oe = !l_r.scl_oe;
                end
                if (cond && !l_r.master && l_r.cnt == 4'd0 && !l_r.addr) begin
                    ev         = 1'b1;
                    ec         = SC_SR_STOP;
                    l_n.st     = ST_IDLE;
                    l_n.sda_oe = 1'b0;
                    l_n.scl_oe = 1'b0;
                end else if (cond && !(l_r.addr && l_r.cnt == 4'd0)) begin
                    ev         = 1'b1;
                    ec         = SC_BUS_ERR;
                    eclr       = 1'b1;
                    l_n.st     = ST_IDLE;
                    l_n.master = 1'b0;
                    l_n.sda_oe = 1'b0;
                    l_n.scl_oe = 1'b0;
                end else if (rise) begin
                    if (l_r.cnt == 4'd8) begin
                        l_n.ackr = !l_r.sda_s;
                    end else begin
                        l_n.sh = {l_r.sh[6:0], l_r.sda_s};
                    end
                end else if (fall) begin
                    if (l_r.cnt == 4'd8) begin
                        ev         = 1'b1;
                        ec         = f_code(l_r.master, l_r.addr, l_r.tx, l_r.rw, l_r.ackr, l_r.gc,
                                            l_r.cmd.aa);
                        l_n.sda_oe = 1'b0;
                        l_n.scl_oe = 1'b1;
                        l_n.st     = ST_WAIT;
                        l_n.addr   = 1'b0;
                        if (l_r.addr) begin
                            l_n.tx = l_r.master ? !l_r.rw : l_r.rw;
                        end
                        // a slave that gave or got the last byte drops out of the transfer
                        if (!l_r.master && !l_r.addr && (l_r.tx ? !(l_r.ackr && l_r.cmd.aa) : !l_r.cmd.aa)) begin
                            l_n.st     = ST_IDLE;
                            l_n.scl_oe = 1'b0;
                        end
                    end else begin
                        l_n.cnt = l_r.cnt + 4'd1;
                        if (l_r.cnt != 4'd7) begin
                            l_n.sda_oe = l_r.tx && !l_r.sh[7];
                        end else if (l_r.addr && !l_r.master) begin
                            l_n.rw     = l_r.sh[0];
                            l_n.gc     = mg;
                            l_n.sda_oe = mo || mg;
                            if (!(mo || mg)) begin
                                l_n.st = ST_IDLE;
                            end
                        end else begin
                            if (l_r.addr) begin
                                l_n.rw = l_r.sh[0];
                            end
                            l_n.sda_oe = !l_r.tx && l_r.cmd.aa;
                        end
                    end
                end
            end
        endcase
        if (!l_r.en_s) begin
            l_n.st     = ST_IDLE;
            l_n.sda_oe = 1'b0;
            l_n.scl_oe = 1'b0;
            l_n.master = 1'b0;
            ev         = 1'b0;
        end
        if (ev) begin
            l_n.ev_tog = !l_r.ev_tog;
            l_n.evt    = '{code: ec, data: l_r.sh, si: esi, clr: eclr};
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            c_r <= CORE_RST;
        end else begin
            c_r <= c_n;
        end
    end

    always_ff @(posedge bus_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            l_r <= LINK_RST;
        end else begin
            l_r <= l_n;
        end
    end

    assign avs_readdata_out    = {24'h000000, c_r.rd};
    assign avs_waitrequest_out = c_r.wt;
    assign scl_out             = 1'b0;
    assign sda_out             = 1'b0;
    assign scl_oe_out          = l_r.scl_oe;
    assign sda_oe_out          = l_r.sda_oe;

    property p_si_sticky;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        c_r.ctrl[B_SI] && !(wctl && !wd[B_SI]) |=> c_r.ctrl[B_SI];
    endproperty
    a_si_sticky: assert property (p_si_sticky) else $error("interrupt flag dropped");

    property p_code_with_flag;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        c_ev && l_r.evt.si |=> c_r.ctrl[B_SI] && c_r.code == $past(l_r.evt.code[7:3]);
    endproperty
    a_code_with_flag: assert property (p_code_with_flag) else $error("code and flag apart");

    property p_err_clears_stop;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        c_ev && l_r.evt.code == SC_BUS_ERR |=> !c_r.ctrl[B_STO] && c_r.code == 5'h00;
    endproperty
    a_err_clears_stop: assert property (p_err_clears_stop) else $error("bus error kept stop");

    property p_code_low_zero;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        avs_read_in && !avs_waitrequest_out && avs_address_in == ADR_CODE |-> avs_readdata_out[2:0] == 3'b000;
    endproperty
    a_code_low_zero: assert property (p_code_low_zero) else $error("code low bits not zero");

    property p_own_store;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        acc && avs_address_in == ADR_OADR |=> c_r.oadr == $past(wd);
    endproperty
    a_own_store: assert property (p_own_store) else $error("own address not stored");

    property p_rate_store;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        wctl |=> c_r.cmd.rate == {$past(wd[7]), $past(wd[1:0])};
    endproperty
    a_rate_store: assert property (p_rate_store) else $error("rate select wrong");

    property p_disable_release;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        !l_r.en_s |=> !l_r.sda_oe && !l_r.scl_oe && l_r.st == ST_IDLE;
    endproperty
    a_disable_release: assert property (p_disable_release) else $error("bus driven while off");

    property p_ack_slot;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        l_r.st == ST_BIT && l_r.cnt == 4'd8 && $past(l_r.cnt) == 4'd8 && !l_r.addr
        |-> l_r.sda_oe == (!l_r.tx && l_r.cmd.aa);
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("ack slot wrong");

    property p_slave_needs_aa;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        l_r.ev_tog != $past(l_r.ev_tog) && (l_r.evt.code == SC_SR_OWN || l_r.evt.code == SC_ST_OWN)
        |-> l_r.cmd.aa;
    endproperty
    a_slave_needs_aa: assert property (p_slave_needs_aa) else $error("addressed without ack enable");

    property p_gen_needs_gc;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        l_r.ev_tog != $past(l_r.ev_tog) && l_r.evt.code == SC_SR_GEN |-> l_r.cmd.own[B_GC] && l_r.cmd.aa;
    endproperty
    a_gen_needs_gc: assert property (p_gen_needs_gc) else $error("broadcast taken while off");
endmodule : twu_top

// *** test/twu_slave_model.sv ***
// write-only two-wire slave that acknowledges its address and keeps the last data byte
// assumes resolved open-drain lines with pull-ups; the pin is only driven low
`timescale 1ns/10ps
module twu_slave_model #(
    parameter logic [6:0] NODE = 7'h50
) (
    // bus lines
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // pull-down and observation
    output logic            sda_oe_out,
    output logic [7:0]      byte_out,
    output logic            stop_out
);
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       sel;
    logic       first;
    initial begin
        {cnt, sh, sel, first, sda_oe_out, byte_out, stop_out} = '0;
    end
    always @(negedge sda_in) if (scl_in) begin
        cnt = 4'h0;
        first = 1'b1;
        stop_out = 1'b0;
    end
    always @(posedge sda_in) if (scl_in) begin
        stop_out = 1'b1;
        sel = 1'b0;
    end
    always @(posedge scl_in) if (cnt < 4'h8) begin
        sh = {sh[6:0], sda_in};
        cnt = cnt + 4'h1;
    end
    // the acknowledge slot is held from one falling clock edge to the next
    always @(negedge scl_in) begin
        if (cnt == 4'h8) begin
            if (first) sel = (sh[7:1] == NODE);
            else if (sel) byte_out = sh;
            sda_oe_out = sel;
            first = 1'b0;
            cnt = 4'h9;
        end else if (cnt == 4'h9) begin
            sda_oe_out = 1'b0;
            cnt = 4'h0;
        end
    end
endmodule : twu_slave_model

// *** test/twu_top_tb.sv ***
// testbench of the two-wire unit: register accesses and a short master write
// assumes HALF_BASE of 4: the engine sees its own clock edges three link cycles late,
// so a shorter half period would move data while the clock is high
`timescale 1ns/10ps
module twu_top_tb;
    import twu_pkg::*;
    logic        clk, bclk, arst_n, rd_s, wr_s, wt, scl_oe, sda_oe, m_oe, m_stop;
    logic        scl_o, sda_o, b_oe;
    logic [9:0]  adr;
    logic [31:0] wd, rdat;
    logic [7:0]  q, m_byte;
    int          failures, total_checks;
    wire logic   scl = ~scl_oe;
    wire logic   sda = ~(sda_oe | m_oe | b_oe);
    twu_top #(.HALF_BASE(16'h0004)) u_twu_top (.core_clk_in(clk), .bus_clk_in(bclk), .arst_n_in(arst_n),
        .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
        .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe));
    twu_slave_model u_twu_slave_model (.scl_in(scl), .sda_in(sda), .sda_oe_out(m_oe), .byte_out(m_byte),
        .stop_out(m_stop));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // link clock starts off phase with the core clock
    initial begin
        bclk = 1'b0;
        #7;
        forever #15 bclk = ~bclk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one access held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        rd_s <= ~w;
        wr_s <= w;
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 100);
        r = rdat[7:0];
        if (n >= 100) chk("waitrequest", 8'h00, 8'h01);
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : bus
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rc(input string nm, input logic [9:0] a, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(nm, e, r);
    endtask : rc
    // polls the state code under a bounded count
    task automatic wait_code(input logic [7:0] e);
        logic [7:0] r;
        int n;
        n = 0;
        do begin
            bus(1'b0, ADR_CODE, 8'h00, r);
            n++;
        end while (r !== e && n < 300);
        chk("state_code", e, r);
    endtask : wait_code
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        #500us;
        failures++;
        summarize();
    end
    initial begin
        {arst_n, rd_s, wr_s, adr, wd, failures, total_checks, b_oe} = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rc("ctrl_rst", ADR_CTRL, CTRL_RST);
        rc("code_rst", ADR_CODE, SC_IDLE);
        rc("data_rst", ADR_DATA, DATA_RST);
        rc("own_rst", ADR_OADR, OADR_RST);
        wr(ADR_OADR, 8'hA1);
        rc("own", ADR_OADR, 8'hA1);
        wr(ADR_DATA, 8'h5A);
        rc("data", ADR_DATA, 8'h5A);
        wr(ADR_CODE, 8'h57);
        rc("code_ro", ADR_CODE, SC_IDLE);
        rc("unmapped", 10'h3FC, 8'h00);
        wr(ADR_CTRL, 8'h83);
        rc("rate", ADR_CTRL, 8'h83);
        wr(ADR_CTRL, 8'hA3);
        repeat (300) @(posedge clk);
        rc("disabled", ADR_CODE, SC_IDLE);
        chk("disabled_lines", 8'h00, {6'h0, scl_oe, sda_oe});
        wr(ADR_CTRL, 8'h00);
        wr(ADR_CTRL, 8'h60);
        wait_code(SC_START);
        rc("si_set", ADR_CTRL, 8'h68);
        wr(ADR_DATA, 8'hA0);
        wr(ADR_CTRL, 8'h40);
        wait_code(SC_MT_AACK);
        repeat (200) @(posedge clk);
        rc("si_held", ADR_CTRL, 8'h48);
        wr(ADR_DATA, 8'h3C);
        wr(ADR_CTRL, 8'h40);
        wait_code(SC_MT_DACK);
        chk("byte_on_bus", 8'h3C, m_byte);
        wr(ADR_CTRL, 8'h50);
        wait_code(SC_IDLE);
        rc("sto_cleared", ADR_CTRL, 8'h40);
        chk("stop_seen", 8'h01, {7'h0, m_stop});
        // bus error: data pulled low by the bench while the clock is high in mid-address
        wr(ADR_CTRL, 8'h60);
        wait_code(SC_START);
        wr(ADR_DATA, 8'hFF);
        wr(ADR_CTRL, 8'h40);
        // a stop request written while the byte moves is only stored, so the error must clear it
        wr(ADR_CTRL, 8'h50);
        repeat (2) @(posedge scl);
        @(posedge bclk);
        b_oe <= 1'b1;
        wait_code(SC_BUS_ERR);
        chk("err_lines", 8'h00, {6'h0, scl_oe, sda_oe});
        rc("err_ctrl", ADR_CTRL, 8'h48);
        @(posedge bclk);
        b_oe <= 1'b0;
        summarize();
    end
endmodule : twu_top_tb
